// ---- console_ctrl_pkg.sv ----
package console_ctrl_pkg;

    // ==========================================================
    // Register map (byte addresses, one word each)
    // ==========================================================
    localparam logic [3:0] OFF_CONFIG   = 4'h0;
    localparam logic [3:0] OFF_TAP      = 4'h4;
    localparam logic [3:0] OFF_STATUS   = 4'h8;

    // ==========================================================
    // Config word fields
    // ==========================================================
    localparam int CFG_ROUTE_POS  = 0;   // 3 bits, mode 1..5
    localparam int CFG_GAIN_POS   = 3;   // 0 low, 1 high
    localparam int CFG_MINLVL_POS = 4;   // 0 minus 40 dB, 1 full mute
    localparam int CFG_SIDE_POS   = 5;   // 2 bits
    localparam int CFG_MAIN_POS   = 7;   // 3 bits
    localparam int CFG_TALK_POS   = 10;  // 2 bits
    localparam logic [11:0] CONFIG_RST  = 12'h001;
    localparam logic [15:0] TAP_RST     = 16'h1388;  // 0.5 ms at 10 MHz
    localparam logic [7:0]  KNOB_MAX    = 8'hFF;
    localparam logic [7:0]  FLOOR_40DB  = 8'h03;     // about 1/100 of full

    typedef enum logic [2:0] {
        MAIN_PUSH_MUTE, MAIN_PUSH_TALK, MAIN_LATCH,
        MAIN_TALK_TAP, MAIN_MUTE_TAP
    } main_mode_t;

    typedef enum logic [1:0] {
        TALK_PUSH, TALK_LATCH, TALK_TAP
    } talk_mode_t;

    typedef enum logic [1:0] {
        SIDE_OFF, SIDE_MAIN, SIDE_TALK, SIDE_BOTH
    } side_mode_t;

    typedef struct packed {
        logic [7:0] left1;
        logic [7:0] right1;
        logic [7:0] left2;
        logic [7:0] right2;
        logic [7:0] left34;
        logic [7:0] right34;
        logic [7:0] side;
    } gains_t;

    typedef struct packed {
        logic red;
        logic green;
    } led_t;

endpackage : console_ctrl_pkg

// ---- talk_button_monitor_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module talk_button_monitor_control
    import console_ctrl_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    input  wire logic [3:0]           i_avs_address,
    input  wire logic                 i_avs_read,
    input  wire logic                 i_avs_write,
    input  wire logic [31:0]          i_avs_writedata,
    output var  logic [31:0]          o_avs_readdata,
    output var  logic                 o_avs_waitrequest,
    input  wire logic                 i_main_btn,
    input  wire logic [2:0]           i_talk_btn,
    input  wire logic [7:0]           i_knob1,
    input  wire logic [7:0]           i_knob2,
    input  wire logic [7:0]           i_knob3,
    output var  console_ctrl_pkg::gains_t o_gains,
    output var  logic                 o_gain_high,
    output var  logic                 o_main_audio_on,
    output var  logic [2:0]           o_talk_audio_on,
    output var  logic                 o_sidetone_on,
    output var  console_ctrl_pkg::led_t o_main_led,
    output var  logic [2:0]           o_talk_led_green
);
    import console_ctrl_pkg::*;

    // ==========================================================
    // Bus slave
    // ==========================================================
    logic [11:0] config_word, next_config_word;
    logic [15:0] tap_limit, next_tap_limit;
    logic        bus_ack, next_bus_ack;
    logic [31:0] next_readdata;

    always_comb begin
        next_config_word = config_word;
        next_tap_limit   = tap_limit;
        next_bus_ack     = (i_avs_read | i_avs_write) & ~bus_ack;
        next_readdata    = o_avs_readdata;
        if (i_avs_write && bus_ack) begin
            if (i_avs_address == OFF_CONFIG)
                next_config_word = i_avs_writedata[11:0];
            if (i_avs_address == OFF_TAP)
                next_tap_limit = i_avs_writedata[15:0];
        end
        if (i_avs_read && !bus_ack) begin
            unique case (i_avs_address)
                OFF_CONFIG: next_readdata = {20'h00000, config_word};
                OFF_TAP:    next_readdata = {16'h0000, tap_limit};
                OFF_STATUS: next_readdata = {27'h0000000, o_sidetone_on,
                                             o_talk_audio_on,
                                             o_main_audio_on};
                default:    next_readdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            config_word       <= CONFIG_RST;
            tap_limit         <= TAP_RST;
            bus_ack           <= 1'b0;
            o_avs_readdata    <= 32'h00000000;
            o_avs_waitrequest <= 1'b1;
        end else begin
            config_word       <= next_config_word;
            tap_limit         <= next_tap_limit;
            bus_ack           <= next_bus_ack;
            o_avs_readdata    <= next_readdata;
            o_avs_waitrequest <= ~next_bus_ack;
        end
    end

    // ==========================================================
    // Config decode
    // ==========================================================
    logic [2:0] route;
    logic       min_mute;
    side_mode_t side_mode;
    main_mode_t main_mode;
    talk_mode_t talk_mode;

    assign route     = config_word[CFG_ROUTE_POS +: 3];
    assign min_mute  = config_word[CFG_MINLVL_POS];
    assign side_mode = side_mode_t'(config_word[CFG_SIDE_POS +: 2]);
    assign main_mode = main_mode_t'(config_word[CFG_MAIN_POS +: 3]);
    assign talk_mode = talk_mode_t'(config_word[CFG_TALK_POS +: 2]);

    // ==========================================================
    // Press timing and button states
    // ==========================================================
    // Index 0 is main, 1..3 are talkback
    logic [3:0]  btn_now, btn_prev, next_btn_prev;
    logic [3:0]  latched, next_latched;
    logic [3:0]  is_hold, next_is_hold;
    logic [15:0] press_cnt [4];
    logic [15:0] next_press_cnt [4];

    assign btn_now = {i_talk_btn, i_main_btn};

    // Tap when release arrives before hold was reached
    function automatic logic toggles(input logic mode_tap, input logic rise,
                                     input logic fall, input logic hold);
        toggles = mode_tap ? (fall & ~hold) : rise;
    endfunction

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_btn
            logic tap_mode;
            logic latch_mode;
            assign tap_mode = (g == 0)
                ? (main_mode == MAIN_TALK_TAP || main_mode == MAIN_MUTE_TAP)
                : (talk_mode == TALK_TAP);
            assign latch_mode = (g == 0) ? (main_mode == MAIN_LATCH)
                                         : (talk_mode == TALK_LATCH);
            always_comb begin
                next_btn_prev[g]  = btn_now[g];
                next_press_cnt[g] = btn_now[g] ? ((press_cnt[g] == 16'hFFFF)
                    ? press_cnt[g] : press_cnt[g] + 16'h0001) : 16'h0000;
                next_is_hold[g]   = btn_now[g] &
                                    (press_cnt[g] >= tap_limit);
                next_latched[g]   = latched[g];
                if ((tap_mode || latch_mode) &&
                    toggles(tap_mode, btn_now[g] & ~btn_prev[g],
                            ~btn_now[g] & btn_prev[g], is_hold[g]))
                    next_latched[g] = ~latched[g];
                if (!tap_mode && !latch_mode)
                    next_latched[g] = 1'b0;
            end
            always_ff @(posedge i_clk) begin
                if (i_sys_rst) begin
                    btn_prev[g]  <= 1'b0;
                    press_cnt[g] <= 16'h0000;
                    is_hold[g]   <= 1'b0;
                    latched[g]   <= 1'b0;
                end else begin
                    btn_prev[g]  <= next_btn_prev[g];
                    press_cnt[g] <= next_press_cnt[g];
                    is_hold[g]   <= next_is_hold[g];
                    latched[g]   <= next_latched[g];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Function state, sidetone and LEDs
    // ==========================================================
    logic       main_on;
    logic [2:0] talk_on;
    logic       side_on;

    always_comb begin
        unique case (main_mode)
            MAIN_PUSH_MUTE: main_on = ~btn_now[0];
            MAIN_PUSH_TALK: main_on = btn_now[0];
            MAIN_LATCH:     main_on = latched[0];
            MAIN_TALK_TAP:  main_on = latched[0] |
                                      (btn_now[0] & is_hold[0]);
            MAIN_MUTE_TAP:  main_on = latched[0] &
                                      ~(btn_now[0] & is_hold[0]);
            default:        main_on = 1'b0;
        endcase
        for (int i = 0; i < 3; i++) begin
            unique case (talk_mode)
                TALK_PUSH:  talk_on[i] = btn_now[i+1];
                TALK_LATCH: talk_on[i] = latched[i+1];
                TALK_TAP:   talk_on[i] = latched[i+1] |
                                (btn_now[i+1] & is_hold[i+1]);
                default:    talk_on[i] = 1'b0;
            endcase
        end
        unique case (side_mode)
            SIDE_OFF:  side_on = 1'b0;
            SIDE_MAIN: side_on = main_on;
            SIDE_TALK: side_on = |talk_on;
            SIDE_BOTH: side_on = main_on | (|talk_on);
        endcase
    end

    // ==========================================================
    // Headphone gains
    // ==========================================================
    function automatic logic [7:0] floor_lvl(input logic [7:0] k,
                                             input logic mute);
        if (k == 8'h00)
            floor_lvl = mute ? 8'h00 : FLOOR_40DB;
        else if (!mute && k < FLOOR_40DB)
            floor_lvl = FLOOR_40DB;
        else
            floor_lvl = k;
    endfunction

    function automatic logic [7:0] scale(input logic [7:0] a,
                                         input logic [7:0] b);
        logic [15:0] p;
        p = a * b;
        scale = p[15:8];
    endfunction

    gains_t next_gains;
    logic [7:0] k1, k2, k3, bal_l, bal_r;

    always_comb begin
        k1 = floor_lvl(i_knob1, min_mute);
        k2 = floor_lvl(i_knob2, min_mute);
        k3 = floor_lvl(i_knob3, min_mute);
        bal_l = (min_mute && i_knob2 == KNOB_MAX) ? 8'h00 :
                ((i_knob2 < 8'h80) ? KNOB_MAX : 8'((KNOB_MAX - i_knob2) << 1));
        bal_r = (min_mute && i_knob2 == 8'h00) ? 8'h00 :
                ((i_knob2 >= 8'h80) ? KNOB_MAX : 8'(i_knob2 << 1));
        next_gains = '0;
        next_gains.side = side_on ? i_knob3 : 8'h00;
        unique case (route)
            3'd1: begin
                next_gains.left1  = k1;
                next_gains.right2 = k2;
            end
            3'd2: begin
                next_gains.left1  = floor_lvl(scale(k1, bal_l),
                                              min_mute);
                next_gains.right2 = floor_lvl(scale(k1, bal_r),
                                              min_mute);
            end
            3'd3: begin
                next_gains.left1   = k1;
                next_gains.right2  = k1;
                next_gains.left34  = k2;
                next_gains.right34 = k2;
            end
            3'd4: begin
                next_gains.left1   = k1;
                next_gains.right2  = k2;
                next_gains.left34  = k3;
                next_gains.right34 = k3;
                next_gains.side    = 8'h00;
            end
            3'd5: begin
                next_gains.left1   = k1;
                next_gains.right1  = k1;
                next_gains.left2   = k2;
                next_gains.right2  = k2;
                next_gains.left34  = k3;
                next_gains.right34 = k3;
                next_gains.side    = 8'h00;
            end
            default: next_gains.side = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_gains          <= '0;
            o_gain_high      <= 1'b0;
            o_main_audio_on  <= 1'b0;
            o_talk_audio_on  <= 3'b000;
            o_sidetone_on    <= 1'b0;
            o_main_led       <= '{red: 1'b1, green: 1'b0};
            o_talk_led_green <= 3'b000;
        end else begin
            o_gains          <= next_gains;
            o_gain_high      <= config_word[CFG_GAIN_POS];
            o_main_audio_on  <= main_on;
            o_talk_audio_on  <= talk_on;
            o_sidetone_on    <= side_on;
            o_main_led       <= '{red: ~main_on, green: main_on};
            o_talk_led_green <= talk_on;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_side_off;
        @(posedge i_clk) disable iff (i_sys_rst)
        (side_mode == SIDE_OFF) |=> !o_sidetone_on;
    endproperty
    a_side_off: assert property (p_side_off)
        else $error("sidetone on while off");

    property p_side_main;
        @(posedge i_clk) disable iff (i_sys_rst)
        (side_mode == SIDE_MAIN) |=> (o_sidetone_on == o_main_audio_on);
    endproperty
    a_side_main: assert property (p_side_main)
        else $error("main sidetone mismatch");

    property p_side_talk;
        @(posedge i_clk) disable iff (i_sys_rst)
        (side_mode == SIDE_TALK) |=> (o_sidetone_on == |o_talk_audio_on);
    endproperty
    a_side_talk: assert property (p_side_talk)
        else $error("talk sidetone mismatch");

    property p_push_mute;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!i_sys_rst && main_mode == MAIN_PUSH_MUTE) |=>
            (o_main_audio_on == !$past(i_main_btn)) && o_main_led.green
            == o_main_audio_on;
    endproperty
    a_push_mute: assert property (p_push_mute)
        else $error("push to mute wrong");

    property p_push_talk;
        @(posedge i_clk) disable iff (i_sys_rst)
        (main_mode == MAIN_PUSH_TALK) |=>
            (o_main_audio_on == $past(i_main_btn)) && o_main_led.red
            == !o_main_audio_on;
    endproperty
    a_push_talk: assert property (p_push_talk)
        else $error("push to talk wrong");

    property p_mode4;
        @(posedge i_clk) disable iff (i_sys_rst)
        (route == 3'd4 && min_mute && i_knob3 == 8'h00) |=>
            o_gains.left34 == 8'h00 && o_gains.side == 8'h00;
    endproperty
    a_mode4: assert property (p_mode4)
        else $error("mode 4 routing wrong");

    property p_floor;
        @(posedge i_clk) disable iff (i_sys_rst)
        (route == 3'd5 && !min_mute && i_knob1 == 8'h00) |=>
            o_gains.left1 == FLOOR_40DB && o_gains.right1 == FLOOR_40DB;
    endproperty
    a_floor: assert property (p_floor)
        else $error("floor not kept");

    property p_side_zero;
        @(posedge i_clk) disable iff (i_sys_rst)
        (route == 3'd1 && i_knob3 == 8'h00) |=> o_gains.side == 8'h00;
    endproperty
    a_side_zero: assert property (p_side_zero)
        else $error("sidetone not muted");

    property p_side_both;
        @(posedge i_clk) disable iff (i_sys_rst)
        (side_mode == SIDE_BOTH) |=>
            (o_sidetone_on == (o_main_audio_on | (|o_talk_audio_on)));
    endproperty
    a_side_both: assert property (p_side_both)
        else $error("combined sidetone mismatch");

    property p_talk_push;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!i_sys_rst && talk_mode == TALK_PUSH) |=>
            (o_talk_audio_on == $past(i_talk_btn)) &&
            (o_talk_led_green == o_talk_audio_on);
    endproperty
    a_talk_push: assert property (p_talk_push)
        else $error("talkback push to talk wrong");

    property p_balance_mute;
        @(posedge i_clk) disable iff (i_sys_rst)
        (route == 3'd2 && min_mute && i_knob2 == 8'h00) |=>
            o_gains.right2 == 8'h00;
    endproperty
    a_balance_mute: assert property (p_balance_mute)
        else $error("balance end not muted");

endmodule : talk_button_monitor_control
`default_nettype wire

// ---- front_panel_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Front panel: debounced buttons and level knobs
// ==========================================================
module front_panel_model (
    input  wire logic       i_clk,
    output var  logic       o_main_btn,
    output var  logic [2:0] o_talk_btn,
    output var  logic [7:0] o_knob1,
    output var  logic [7:0] o_knob2,
    output var  logic [7:0] o_knob3
);
    initial begin
        o_main_btn = 1'b0;
        o_talk_btn = 3'h0;
        o_knob1    = 8'h00;
        o_knob2    = 8'h00;
        o_knob3    = 8'h00;
    end

    // Button 3 is main, 0..2 are talkback
    task automatic set_btn(input int b, input logic v);
        @(posedge i_clk);
        if (b == 3) begin
            o_main_btn <= v;
        end else begin
            o_talk_btn[b] <= v;
        end
    endtask : set_btn

    task automatic set_knobs(input logic [23:0] k);
        @(posedge i_clk);
        o_knob1 <= k[23:16];
        o_knob2 <= k[15:8];
        o_knob3 <= k[7:0];
    endtask : set_knobs
endmodule : front_panel_model
`default_nettype wire

// ---- talk_button_monitor_control_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin samples_checked++; \
    if ((got) !== (exp)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module talk_button_monitor_control_bench;
    import console_ctrl_pkg::*;
    logic        clk, sys_rst, avs_read, avs_write, main_btn;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        avs_waitrequest, gain_high, main_on, side_on;
    logic [2:0]  talk_btn, talk_on, talk_green;
    logic [7:0]  knob1, knob2, knob3;
    gains_t      gains;
    led_t        main_led;
    int          n_mismatch, samples_checked;
    logic [4:0]  main_exp [5] = '{5'b11011, 5'b00100, 5'b01001,
                                  5'b01110, 5'b01010};
    logic [4:0]  talk_exp [3] = '{5'b00100, 5'b01001, 5'b01110};

    // ==========================================================
    // Clock, reset and instances
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    front_panel_model panel (.i_clk(clk), .o_main_btn(main_btn),
        .o_talk_btn(talk_btn), .o_knob1(knob1), .o_knob2(knob2),
        .o_knob3(knob3));

    talk_button_monitor_control uut (.i_clk(clk), .i_sys_rst(sys_rst),
        .i_avs_address(avs_address), .i_avs_read(avs_read),
        .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
        .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
        .i_main_btn(main_btn), .i_talk_btn(talk_btn), .i_knob1(knob1),
        .i_knob2(knob2), .i_knob3(knob3), .o_gains(gains),
        .o_gain_high(gain_high), .o_main_audio_on(main_on),
        .o_talk_audio_on(talk_on), .o_sidetone_on(side_on),
        .o_main_led(main_led), .o_talk_led_green(talk_green));

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    function automatic logic [31:0] cfg(input logic [2:0] rt,
        input logic g, input logic mt, input logic [1:0] sd,
        input logic [2:0] mm, input logic [1:0] tm);
        return {20'h0, tm, mm, sd, mt, g, rt};
    endfunction : cfg

    task automatic chk(input int b, input logic on);
        if (b == 3) begin
            `CHECK(main_on, on)
            `CHECK(main_led, {~on, on})
        end else begin
            `CHECK(talk_on, 3'(on) << b)
            `CHECK(talk_green, 3'(on) << b)
        end
        `CHECK(side_on, on)
    endtask : chk

    // Idle, tap, held, after release, tap
    task automatic do_seq(input int b, input logic [4:0] e);
        step(3);
        chk(b, e[4]);
        panel.set_btn(b, 1'b1);
        panel.set_btn(b, 1'b0);
        step(4);
        chk(b, e[3]);
        panel.set_btn(b, 1'b1);
        step(10);
        chk(b, e[2]);
        panel.set_btn(b, 1'b0);
        step(4);
        chk(b, e[1]);
        panel.set_btn(b, 1'b1);
        panel.set_btn(b, 1'b0);
        step(4);
        chk(b, e[0]);
    endtask : do_seq

    task automatic route_case(input logic [2:0] rt, input logic g,
        input logic mt, input logic [23:0] k, input logic [55:0] e);
        bus(1'b1, OFF_CONFIG, cfg(rt, g, mt, 2'd1, 3'd0, 2'd0), q);
        panel.set_knobs(k);
        step(4);
        `CHECK(gains, e)
        `CHECK(gain_high, g)
    endtask : route_case

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done();
    end

    initial begin
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        n_mismatch = 0;
        samples_checked = 0;
        sys_rst = 1'b1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        bus(1'b0, OFF_CONFIG, 32'h0, q);
        `CHECK(q, 32'h0000_0001)
        bus(1'b0, OFF_TAP, 32'h0, q);
        `CHECK(q, 32'h0000_1388)
        bus(1'b0, 4'hC, 32'h0, q);
        `CHECK(q, 32'h0000_0000)
        bus(1'b1, OFF_TAP, 32'h0000_0004, q);
        bus(1'b0, OFF_TAP, 32'h0, q);
        `CHECK(q, 32'h0000_0004)
        for (int m = 0; m < 5; m++) begin
            bus(1'b1, OFF_CONFIG, cfg(3'd1, 0, 0, 2'd1, 3'd1, 2'd0), q);
            bus(1'b1, OFF_CONFIG, cfg(3'd1, 0, 0, 2'd1, 3'(m), 2'd0), q);
            do_seq(3, main_exp[m]);
        end
        for (int m = 0; m < 3; m++) begin
            bus(1'b1, OFF_CONFIG, cfg(3'd1, 0, 0, 2'd2, 3'd1, 2'd0), q);
            bus(1'b1, OFF_CONFIG, cfg(3'd1, 0, 0, 2'd2, 3'd1, 2'(m)), q);
            do_seq(m, talk_exp[m]);
        end
        bus(1'b1, OFF_CONFIG, cfg(3'd1, 0, 0, 2'd3, 3'd0, 2'd0), q);
        step(3);
        `CHECK(side_on, 1'b1)
        bus(1'b1, OFF_CONFIG, cfg(3'd1, 0, 0, 2'd0, 3'd0, 2'd0), q);
        step(3);
        `CHECK(side_on, 1'b0)
        bus(1'b0, OFF_STATUS, 32'h0, q);
        `CHECK(q, 32'h0000_0001)
        route_case(3'd4, 1, 0, 24'hFF00FF, 56'hFF000003FFFF00);
        route_case(3'd4, 1, 1, 24'hFF00FF, 56'hFF000000FFFF00);
        route_case(3'd4, 0, 1, 24'h00FF00, 56'h000000FF000000);
        route_case(3'd2, 0, 1, 24'hFF0000, 56'hFE000000000000);
        route_case(3'd2, 0, 1, 24'hFFFF00, 56'h000000FE000000);
        route_case(3'd2, 0, 0, 24'hFF0000, 56'hFE000003000000);
        route_case(3'd5, 0, 0, 24'h00FF00, 56'h0303FFFF030300);
        route_case(3'd5, 0, 1, 24'h00FF00, 56'h0000FFFF000000);
        route_case(3'd1, 0, 0, 24'hFF0000, 56'hFF000003000000);
        route_case(3'd1, 1, 0, 24'h0000FF, 56'h030000030000FF);
        test_done();
    end
endmodule : talk_button_monitor_control_bench
`default_nettype wire
